// ==== common/dfm_pkg.sv ====
// Purpose: constants and types of the digital input function map
// Assumes: one 100 MHz clock, APB register access
// Notes:   codes are the values software writes into a selector
// Operation
// (RULE1) each terminal has its own 16-bit selector
// (RULE2) codes 1-4 speed step bits, 0 none
// (RULE3) code 6 gives an inch motion request
// (RULE4) code 7 holds present speed
// (RULE5) codes 8, 9 pick ramp time set
// (RULE6) code 10 is external fault input
// (RULE7) code 11 blocks the power output
// (RULE8) code 13 cancels automatic ramp timing
// (RULE9) codes 15, 16 pick analog frequency source
// (RULE10) code 18 forces a stop
// (RULE11) codes 19, 20 step frequency up, down
// (RULE12) code 22 clears counter, 23 counts terminal six
// (RULE13) code 21 turns process control loop off
// (RULE14) codes 26, 27 pick control mode, regulator set
// (RULE15) code 28 raises emergency stop fault
// (RULE16) codes 29, 30 confirm star, delta winding
// (RULE17) codes 31-33 apply high, middle, low bias
// (RULE18) wiring mode zero: terminals one, two normal
// (RULE19) nonzero wiring mode takes terminals one, two; here only modes 1-6 do, values above six count as off
// (RULE20) mode 1 forward/reverse, mode 2 run/direction
// (RULE21) three-wire mode makes terminal three stop
// (RULE22) terminal seven selector zero: pulse input
// (RULE23) modes 3, 6 three-wire; 4-6 quick start
// (RULE24) unlisted codes act as no function
package dfm_pkg;
  localparam int NUM_TERM = 10;  // seven base, three extension
  localparam int SEL_W    = 16;  // selector width
  localparam int IDX_W    = 10;  // register index width
  localparam int ADDR_W   = 12;  // byte address width
  localparam int DATA_W   = 32;  // apb data width
  localparam int CNT_W    = 16;  // counter widths
  localparam int FC_MAX   = 33;  // highest mapped code
  localparam int FC_BITS  = 6;   // code bits used as index
  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE  = 10'h200;
  localparam logic [IDX_W-1:0] IDX_LEVEL = 10'h220;
  localparam logic [IDX_W-1:0] IDX_COUNT = 10'h221;
  localparam logic [IDX_W-1:0] IDX_PULSE = 10'h222;
  localparam logic [IDX_W-1:0] IDX_FUNC  = 10'h223;
  localparam logic [NUM_TERM-1:0][IDX_W-1:0] IDX_SEL = {
    10'h21C, 10'h21B, 10'h21A, 10'h207, 10'h206,
    10'h205, 10'h204, 10'h203, 10'h202, 10'h201};
  localparam logic [NUM_TERM-1:0][SEL_W-1:0] SEL_RST = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0004,
    16'h0003, 16'h0002, 16'h0001, 16'h0000, 16'h0000};
  localparam logic [SEL_W-1:0] MODE_RST = 16'h0000;
  // terminal positions in the pin vector
  localparam int TERM_ONE   = 0;
  localparam int TERM_TWO   = 1;
  localparam int TERM_THREE = 2;
  localparam int TERM_SIX   = 5;
  localparam int TERM_SEVEN = 6;
  // function codes
  localparam int FC_NONE = 0;
  localparam int FC_STEP1 = 1;
  localparam int FC_STEP4 = 4;
  localparam int FC_RESET = 5;
  localparam int FC_INCH = 6;
  localparam int FC_HOLD = 7;
  localparam int FC_RAMP0 = 8;
  localparam int FC_RAMP1 = 9;
  localparam int FC_EXTF = 10;
  localparam int FC_BLOCK = 11;
  localparam int FC_OSTOP = 12;
  localparam int FC_AUTO_OFF = 13;
  localparam int FC_AI1 = 15;
  localparam int FC_AI2 = 16;
  localparam int FC_FSTOP = 18;
  localparam int FC_UP = 19;
  localparam int FC_DOWN = 20;
  localparam int FC_PCL_OFF = 21;
  localparam int FC_CNT_CLR = 22;
  localparam int FC_CNT_IN = 23;
  localparam int FC_INCH_F = 24;
  localparam int FC_INCH_R = 25;
  localparam int FC_TQC = 26;
  localparam int FC_ASR = 27;
  localparam int FC_ESTOP = 28;
  localparam int FC_STAR = 29;
  localparam int FC_DELTA = 30;
  localparam int FC_BIAS_HI = 31;
  localparam int FC_BIAS_LO = 33;
  // codes with a function here; 14 and 17 have none
  localparam logic [FC_MAX:0] FC_IMPL = 34'h3FFFDBFFE;
  // wiring modes
  localparam logic [SEL_W-1:0] WM_2W1  = 16'h0001;
  localparam logic [SEL_W-1:0] WM_2W2  = 16'h0002;
  localparam logic [SEL_W-1:0] WM_3W   = 16'h0003;
  localparam logic [SEL_W-1:0] WM_2W1Q = 16'h0004;
  localparam logic [SEL_W-1:0] WM_2W2Q = 16'h0005;
  localparam logic [SEL_W-1:0] WM_3WQ  = 16'h0006;

  typedef enum logic [1:0] {
    RS_STOP = 2'b00,
    RS_RUN  = 2'b01
  } dfm_run_type;

  typedef struct packed {
    logic       forward_run;          // run forward
    logic       reverse_run;          // run reverse
    logic       quick_start;          // output kept ready
    logic [3:0] step_sel;             // speed step bits
    logic       reset_req;            // fault reset
    logic       inch_motion;          // inch request
    logic       inch_fwd;             // forward inch
    logic       inch_rev;             // reverse inch
    logic       ramp_hold;            // hold present speed
    logic [1:0] ramp_sel;             // ramp time set
    logic       external_fault_input; // external fault
    logic       base_block;           // power output off
    logic       output_stop;          // output stop
    logic       auto_ramp_cancel;     // fixed ramp times
    logic       freq_from_ai1;        // analog source one
    logic       freq_from_ai2;        // analog source two
    logic       forced_stop;          // forced stop
    logic       freq_up;              // step reference up
    logic       freq_down;            // step reference down
    logic       process_control_off;  // loop disabled
    logic       counter_clear;        // counter held clear
    logic       torque_control_sel;   // torque mode chosen
    logic       speed_regulator_set_two; // second gain set
    logic       emergency_stop_fault; // emergency stop
    logic       star_confirm;         // star winding
    logic       delta_confirm;        // delta winding
    logic [2:0] torque_bias;          // high, middle, low
    logic       pulse_edge;           // feedback pulse
  } dfm_func_type;

  typedef struct packed {
    logic [NUM_TERM-1:0]            sync1;   // first stage
    logic [NUM_TERM-1:0]            sync2;   // second stage
    logic [NUM_TERM-1:0]            prev;    // delayed level
    logic [NUM_TERM-1:0][SEL_W-1:0] sel;     // selectors
    logic [SEL_W-1:0]               mode;    // wiring mode
    dfm_run_type                    run;     // three-wire latch
    dfm_func_type                   func;    // mapped outputs
    logic [CNT_W-1:0]               count;   // terminal six count
    logic [CNT_W-1:0]               pulses;  // feedback pulses
    logic [DATA_W-1:0]              prdata;  // read data
    logic                           pslverr; // unmapped access
  } dfm_state_type;

  localparam dfm_state_type STATE_RST = '{
    sel: SEL_RST, mode: MODE_RST, run: RS_STOP, default: '0};
endpackage

// ==== rtl/dfm_input_map.sv ====
// Purpose: map drive input terminals to internal functions
// Assumes: pins are asynchronous contacts, debounced elsewhere
// Notes:   apb slave with zero wait states; outputs registered
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module dfm_input_map
  import dfm_pkg::*;
(
  input  wire logic                mclk,          // 100 MHz clock
  input  wire logic                sys_rst,       // async reset
  input  wire logic [NUM_TERM-1:0] term_pins,     // terminal levels
  input  wire logic                psel,          // apb select
  input  wire logic                penable,       // apb enable
  input  wire logic                pwrite,        // apb direction
  input  wire logic [ADDR_W-1:0]   paddr,         // apb byte address
  input  wire logic [DATA_W-1:0]   pwdata,        // apb write data
  output logic      [DATA_W-1:0]   prdata,        // apb read data
  output logic                     pready,        // apb ready
  output logic                     pslverr,       // apb error
  output dfm_func_type             func_out,      // mapped functions
  output logic      [CNT_W-1:0]    counter_value, // terminal count
  output logic      [CNT_W-1:0]    pulse_count    // feedback pulses
);

  dfm_state_type                 s_q;      // all state
  dfm_state_type                 s_d;      // next state
  logic [NUM_TERM-1:0][FC_MAX:0] hit;      // active code per input
  logic [FC_MAX:0]               any_hit;  // code active anywhere
  logic [NUM_TERM-1:0]           lvl;      // synchronised levels
  logic [NUM_TERM-1:0]           rise;     // rising edges
  logic                          wm_on;    // wiring mode active
  logic                          wm_three; // three-wire mode
  logic                          wm_two1;  // forward/reverse mode
  logic                          wm_two2;  // run/direction mode
  logic                          setup_ph; // apb setup cycle
  logic                          wr_acc;   // apb write access
  logic [IDX_W-1:0]              a_idx;    // register index
  logic                          rd_ok;    // index is mapped
  logic [DATA_W-1:0]             rd_val;   // selected read value
  logic                          cnt_tick; // counter input edge
  logic                          pls_tick; // pulse input edge

  // edges only look at the second stage and its delayed copy
  assign lvl  = s_q.sync2;
  assign rise = s_q.sync2 & ~s_q.prev;

  // wiring mode decode; values above six count as off
  assign wm_on    = (s_q.mode >= WM_2W1) && (s_q.mode <= WM_3WQ);
  assign wm_three = (s_q.mode == WM_3W) || (s_q.mode == WM_3WQ); // [RULE23]
  assign wm_two1  = (s_q.mode == WM_2W1) || (s_q.mode == WM_2W1Q);
  assign wm_two2  = (s_q.mode == WM_2W2) || (s_q.mode == WM_2W2Q);

  // apb phase decode; no wait states, so ready is constant
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign a_idx    = paddr[ADDR_W-1:2];
  assign pready   = 1'b1;

  // outputs straight from state flops
  assign prdata        = s_q.prdata;
  assign pslverr       = s_q.pslverr;
  assign func_out      = s_q.func;
  assign counter_value = s_q.count;
  assign pulse_count   = s_q.pulses;

  // counter counts only on terminal six
  assign cnt_tick = rise[TERM_SIX]
                    && s_q.sel[TERM_SIX] == SEL_W'(FC_CNT_IN); // [RULE12]
  // terminal seven with zero selector feeds pulse feedback
  assign pls_tick = rise[TERM_SEVEN]
                    && s_q.sel[TERM_SEVEN] == SEL_W'(FC_NONE); // [RULE22]

  // per-terminal decode of the selector into a one-hot code
  for (genvar t = 0; t < NUM_TERM; t++)
  begin : g_dec
    logic taken; // terminal owned by the wiring mode
    logic known; // selector names a function here
    always_comb
    begin
      taken = (wm_on && (t == TERM_ONE || t == TERM_TWO))  // [RULE19]
              || (wm_three && t == TERM_THREE);             // [RULE21]
      // out of range or unlisted codes drive nothing
      known = (s_q.sel[t] <= SEL_W'(FC_MAX))
              && FC_IMPL[s_q.sel[t][FC_BITS-1:0]]          // [RULE24]
              && (s_q.sel[t] != SEL_W'(FC_CNT_IN)
                  || t == TERM_SIX);                        // [RULE12]
      hit[t] = '0;
      // own selector steers the terminal when not taken
      if (lvl[t] && !taken && known)                        // [RULE18]
      begin
        hit[t][s_q.sel[t][FC_BITS-1:0]] = 1'b1;             // [RULE1]
      end
    end
  end

  // several terminals may carry one code; they are or-ed
  always_comb
  begin
    any_hit = '0;
    for (int t = 0; t < NUM_TERM; t++)
    begin
      any_hit = any_hit | hit[t];
    end
  end

  // register read mux
  always_comb
  begin
    rd_ok  = 1'b1;
    rd_val = '0;
    case (a_idx)
      IDX_MODE:  rd_val = DATA_W'(s_q.mode);
      IDX_LEVEL: rd_val = DATA_W'(lvl);
      IDX_COUNT: rd_val = DATA_W'(s_q.count);
      IDX_PULSE: rd_val = DATA_W'(s_q.pulses);
      IDX_FUNC:  rd_val = DATA_W'(s_q.func);
      default:   rd_ok  = 1'b0;
    endcase
    // selector indexes are not contiguous, so search them
    for (int t = 0; t < NUM_TERM; t++)
    begin
      if (a_idx == IDX_SEL[t])
      begin
        rd_ok  = 1'b1;
        rd_val = DATA_W'(s_q.sel[t]);
      end
    end
  end

  // next state
  always_comb
  begin
    s_d = s_q;
    // two-flop synchroniser then edge reference
    s_d.sync1 = term_pins;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;

    // three-wire run latch; stop contact opens to stop
    case (s_q.run)
      RS_STOP:
      begin
        if (wm_three && lvl[TERM_THREE] && rise[TERM_ONE]) // [RULE23]
        begin
          s_d.run = RS_RUN;
        end
      end
      RS_RUN:
      begin
        if (!wm_three || !lvl[TERM_THREE])                // [RULE21]
        begin
          s_d.run = RS_STOP;
        end
      end
      default:
      begin
        s_d.run = RS_STOP;
      end
    endcase

    // run and direction from the wiring mode
    if (wm_two1)
    begin
      s_d.func.forward_run = lvl[TERM_ONE];               // [RULE20]
      s_d.func.reverse_run = lvl[TERM_TWO];
    end
    else if (wm_two2)
    begin
      s_d.func.forward_run = lvl[TERM_ONE] && !lvl[TERM_TWO]; // [RULE20]
      s_d.func.reverse_run = lvl[TERM_ONE] && lvl[TERM_TWO];
    end
    else if (wm_three)
    begin
      // direction follows terminal two while latched
      s_d.func.forward_run = (s_d.run == RS_RUN)
                             && !lvl[TERM_TWO];          // [RULE23]
      s_d.func.reverse_run = (s_d.run == RS_RUN) && lvl[TERM_TWO];
    end
    else
    begin
      s_d.func.forward_run = 1'b0;                        // [RULE18]
      s_d.func.reverse_run = 1'b0;
    end
    // quick start keeps the output stage armed
    s_d.func.quick_start = (s_q.mode >= WM_2W1Q)
                           && (s_q.mode <= WM_3WQ);       // [RULE23]

    // selector-driven functions
    s_d.func.step_sel    = any_hit[FC_STEP4:FC_STEP1];    // [RULE2]
    s_d.func.reset_req   = any_hit[FC_RESET];
    s_d.func.inch_motion = any_hit[FC_INCH];              // [RULE3]
    s_d.func.inch_fwd    = any_hit[FC_INCH_F];
    s_d.func.inch_rev    = any_hit[FC_INCH_R];
    s_d.func.ramp_hold   = any_hit[FC_HOLD];              // [RULE4]
    s_d.func.ramp_sel    = any_hit[FC_RAMP1:FC_RAMP0];    // [RULE5]
    s_d.func.external_fault_input = any_hit[FC_EXTF];     // [RULE6]
    s_d.func.base_block  = any_hit[FC_BLOCK];             // [RULE7]
    s_d.func.output_stop = any_hit[FC_OSTOP];
    s_d.func.auto_ramp_cancel = any_hit[FC_AUTO_OFF];     // [RULE8]
    s_d.func.freq_from_ai1 = any_hit[FC_AI1];             // [RULE9]
    s_d.func.freq_from_ai2 = any_hit[FC_AI2];             // [RULE9]
    s_d.func.forced_stop = any_hit[FC_FSTOP];             // [RULE10]
    s_d.func.freq_up     = any_hit[FC_UP];                // [RULE11]
    s_d.func.freq_down   = any_hit[FC_DOWN];              // [RULE11]
    s_d.func.process_control_off = any_hit[FC_PCL_OFF];   // [RULE13]
    s_d.func.counter_clear = any_hit[FC_CNT_CLR];         // [RULE12]
    s_d.func.torque_control_sel = any_hit[FC_TQC];        // [RULE14]
    s_d.func.speed_regulator_set_two = any_hit[FC_ASR];   // [RULE14]
    s_d.func.emergency_stop_fault = any_hit[FC_ESTOP];    // [RULE15]
    s_d.func.star_confirm  = any_hit[FC_STAR];            // [RULE16]
    s_d.func.delta_confirm = any_hit[FC_DELTA];           // [RULE16]
    // bit 2 high, bit 1 middle, bit 0 low bias
    s_d.func.torque_bias = {any_hit[FC_BIAS_HI],
                            any_hit[FC_BIAS_HI+1],
                            any_hit[FC_BIAS_LO]};         // [RULE17]
    s_d.func.pulse_edge = pls_tick;                       // [RULE22]

    // clear is a level and beats a coincident count
    if (any_hit[FC_CNT_CLR])
    begin
      s_d.count = '0;                                     // [RULE12]
    end
    else if (cnt_tick)
    begin
      s_d.count = s_q.count + 1'b1;
    end
    // pulse count wraps; software takes differences
    if (pls_tick)
    begin
      s_d.pulses = s_q.pulses + 1'b1;
    end

    // register writes take effect in the access cycle
    if (wr_acc)
    begin
      if (a_idx == IDX_MODE)
      begin
        s_d.mode = pwdata[SEL_W-1:0];
      end
      for (int t = 0; t < NUM_TERM; t++)
      begin
        if (a_idx == IDX_SEL[t])
        begin
          s_d.sel[t] = pwdata[SEL_W-1:0];                 // [RULE1]
        end
      end
    end
    // read data and error are set up one cycle ahead
    if (setup_ph)
    begin
      s_d.prdata  = pwrite ? '0 : rd_val;
      s_d.pslverr = !rd_ok;
    end
  end

  // single state register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // checks on the mapping
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_sel_store: assert property ( // [RULE1]
    wr_acc && a_idx == IDX_SEL[3]
    |=> s_q.sel[3] == $past(pwdata[SEL_W-1:0]))
    else $error("selector write not stored");

  a_step_bit: assert property ( // [RULE2]
    (term_pins[3] && s_q.sel[3] == SEL_W'(FC_STEP1 + 1)) [*4]
    |-> func_out.step_sel[1])
    else $error("step bit two not driven");

  a_inch_pin: assert property ( // [RULE3]
    (term_pins[3] && s_q.sel[3] == SEL_W'(FC_INCH)) [*4]
    |-> func_out.inch_motion)
    else $error("inch request missing");

  a_two_wire: assert property ( // [RULE20]
    wm_two2 && lvl[TERM_ONE] && lvl[TERM_TWO]
    |=> func_out.reverse_run && !func_out.forward_run)
    else $error("run/direction mode wrong");

  a_three_stop: assert property ( // [RULE21]
    wm_three && !lvl[TERM_THREE]
    |=> !func_out.forward_run && !func_out.reverse_run)
    else $error("stop contact ignored");

  a_quick_flag: assert property ( // [RULE23]
    s_q.mode == WM_3WQ |=> func_out.quick_start)
    else $error("quick start not flagged");

  a_unlisted_none: assert property ( // [RULE24]
    (any_hit & ~FC_IMPL) == '0)
    else $error("unlisted code drove a function");

  a_count_step: assert property ( // [RULE12]
    cnt_tick && !any_hit[FC_CNT_CLR]
    |=> counter_value == $past(counter_value) + 1'b1)
    else $error("counter missed an edge");

  a_pulse_once: assert property ( // [RULE22]
    pls_tick |=> func_out.pulse_edge ##1 !func_out.pulse_edge)
    else $error("pulse edge not one cycle");

  // four samples cover the two syncs and the output flop
  a_fault_pin: assert property ( // [RULE6]
    (term_pins[3] && s_q.sel[3] == SEL_W'(FC_EXTF)) [*4]
    |-> func_out.external_fault_input)
    else $error("external fault not driven");

  a_bias_high: assert property ( // [RULE17]
    (term_pins[3] && s_q.sel[3] == SEL_W'(FC_BIAS_HI)) [*4]
    |-> func_out.torque_bias[2])
    else $error("high torque bias not driven");

  // out of range selectors must not alias onto low codes
  a_far_code: assert property ( // [RULE24]
    s_q.sel[3] > SEL_W'(FC_MAX) |-> hit[3] == '0)
    else $error("out of range code drove a function");

  // a terminal seven with a function must not count pulses
  a_pulse_gate: assert property ( // [RULE22]
    rise[TERM_SEVEN] && s_q.sel[TERM_SEVEN] != SEL_W'(FC_NONE)
    |=> pulse_count == $past(pulse_count))
    else $error("pulse counted with a function set");

  a_clear_wins: assert property ( // [RULE12]
    any_hit[FC_CNT_CLR] |=> counter_value == '0)
    else $error("counter not held clear");

  a_wire_off: assert property ( // [RULE18]
    !wm_on |=> !func_out.forward_run && !func_out.reverse_run)
    else $error("run role without wiring mode");

  c_three_run: cover property (s_q.run == RS_RUN ##1 s_q.run == RS_STOP);
  c_two_rev: cover property (wm_two2 && func_out.reverse_run);
  c_clear: cover property (any_hit[FC_CNT_CLR] && counter_value != '0);
  c_pulse: cover property (func_out.pulse_edge);
  c_count: cover property (cnt_tick ##1 counter_value != '0);

endmodule // dfm_input_map
`default_nettype wire

// ==== sim/dfm_contact_model.sv ====
// Purpose: switch contacts and pulse source on the input terminals
// Assumes: bench sets contact levels just after a rising edge
// Notes:   no bounce, so a level change is a clean step
`timescale 1ns/10ps
`default_nettype none
module dfm_contact_model
  import dfm_pkg::*;
(
  input  wire logic                mclk, // bench clock
  input  wire logic [NUM_TERM-1:0] lvl,  // wanted contact levels
  output logic      [NUM_TERM-1:0] pins  // terminal wires
);
  logic [NUM_TERM-1:0] pls_q; // pulse overlay on the contacts

  // closed contact or pulse both drive the wire high
  assign pins = lvl | pls_q;

  initial pls_q = '0;

  // n pulses, two cycles high, three low; wide enough for the syncs
  task automatic pulse(input int t, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      pls_q[t] <= 1'b1;
      repeat (2) @(posedge mclk);
      pls_q[t] <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule // dfm_contact_model
`default_nettype wire

// ==== sim/tb_digital_input_function_map.sv ====
// Purpose: self-checking bench of the terminal function map
// Assumes: apb master here, contacts in the partner model
// Notes:   notes are queued; a monitor compares at each answer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module tb_digital_input_function_map
  import dfm_pkg::*;
;
  logic                mclk, sys_rst;   // clock, reset
  logic                psel, penable;   // apb phase
  logic                pwrite, prb;     // direction, look strobe
  logic                pready, pslverr; // apb answer
  logic [ADDR_W-1:0]   paddr;           // byte address
  logic [DATA_W-1:0]   pwdata, prdata;  // apb data
  logic [NUM_TERM-1:0] lvl, pins;       // contacts, wires
  dfm_func_type        func_out;        // mapped functions
  logic [CNT_W-1:0]    counter_value;   // terminal six count
  logic [CNT_W-1:0]    pulse_count;     // feedback pulses
  logic [DATA_W:0]     rdq [$];         // read notes {err, data}
  dfm_func_type        fq [$];          // function notes
  int                  n_fail, n_compared;
  // wiring table {mode, pins three..one, {hold, quick, rev, fwd}}
  logic [11:0] tbl [14] = '{12'h018, 12'h111, 12'h122, 12'h133,
    12'h211, 12'h232,
    12'h415, 12'h536, 12'h340, 12'h351, 12'h341, 12'h300,
    12'h644, 12'h718};

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  dfm_input_map uut (.mclk(mclk), .sys_rst(sys_rst),
    .term_pins(pins), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .func_out(func_out), .counter_value(counter_value),
    .pulse_count(pulse_count));

  dfm_contact_model part (.mclk(mclk), .lvl(lvl), .pins(pins));

  // compare each answer with the oldest note
  always @(posedge mclk)
  begin : mon
    logic [DATA_W:0] er;
    dfm_func_type    ef;
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      er = rdq.pop_front();
      `CHK({pslverr, prdata}, er)
      // the count ports must agree with their registers
      if (paddr[ADDR_W-1:2] == IDX_COUNT)
        `CHK(counter_value, er[CNT_W-1:0])
      if (paddr[ADDR_W-1:2] == IDX_PULSE)
        `CHK(pulse_count, er[CNT_W-1:0])
    end
    if (prb)
    begin
      ef = fq.pop_front();
      `CHK(func_out, ef)
    end
  end

  // expected functions of one terminal holding code c
  function automatic dfm_func_type fexp(int c);
    dfm_func_type f;
    f = '0;
    case (c)
      1, 2, 3, 4: f.step_sel[c-1] = 1'b1;
      5:  f.reset_req = 1'b1;
      6:  f.inch_motion = 1'b1;
      7:  f.ramp_hold = 1'b1;
      8:  f.ramp_sel[0] = 1'b1;
      9:  f.ramp_sel[1] = 1'b1;
      10: f.external_fault_input = 1'b1;
      11: f.base_block = 1'b1;
      12: f.output_stop = 1'b1;
      13: f.auto_ramp_cancel = 1'b1;
      15: f.freq_from_ai1 = 1'b1;
      16: f.freq_from_ai2 = 1'b1;
      18: f.forced_stop = 1'b1;
      19: f.freq_up = 1'b1;
      20: f.freq_down = 1'b1;
      21: f.process_control_off = 1'b1;
      22: f.counter_clear = 1'b1;
      24: f.inch_fwd = 1'b1;
      25: f.inch_rev = 1'b1;
      26: f.torque_control_sel = 1'b1;
      27: f.speed_regulator_set_two = 1'b1;
      28: f.emergency_stop_fault = 1'b1;
      29: f.star_confirm = 1'b1;
      30: f.delta_confirm = 1'b1;
      31, 32, 33: f.torque_bias[33-c] = 1'b1;
      default: f = '0;
    endcase
    return f;
  endfunction

  // run-role outputs of the wiring modes
  function automatic dfm_func_type wexp(logic [3:0] x);
    dfm_func_type f;
    f = '0;
    {f.ramp_hold, f.quick_start, f.reverse_run, f.forward_run} = x;
    return f;
  endfunction

  // one apb transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [IDX_W-1:0] i,
                     input logic [DATA_W-1:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read with a noted answer
  task automatic rd(input logic [IDX_W-1:0] i, input logic [DATA_W:0] e);
    rdq.push_back(e);
    apb(1'b0, i, '0);
  endtask

  // set contacts, then let them pass the synchronisers
  task automatic lv(input logic [NUM_TERM-1:0] v);
    @(posedge mclk);
    lvl <= v;
    repeat (5) @(posedge mclk);
  endtask

  // note the functions and strobe the monitor for one cycle
  task automatic look(input dfm_func_type e);
    fq.push_back(e);
    @(posedge mclk);
    prb <= 1'b1;
    @(posedge mclk);
    prb <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog: the whole run needs some 1050 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    logic [DATA_W-1:0] v;
    logic [11:0]       m;
    sys_rst = 1'b1;
    {psel, penable, pwrite, prb} = '0;
    paddr = '0;
    pwdata = '0;
    lvl = '0;
    n_fail = 0;
    n_compared = 0;
    v = $urandom(20884);
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values, unmapped place, random write and readback
    rd(IDX_MODE, {17'h0, MODE_RST});
    rd(10'h300, {1'b1, 32'h0});
    for (int k = 0; k < NUM_TERM; k++)
    begin
      rd(IDX_SEL[k], {17'h0, SEL_RST[k]});
      v = $urandom();
      apb(1'b1, IDX_SEL[k], v);
      rd(IDX_SEL[k], {17'h0, v[15:0]});
      apb(1'b1, IDX_SEL[k], {16'h0, SEL_RST[k]});
    end
    $display("test registers done");
    // every code on terminal four, plus one far out of range
    for (int k = 0; k < 37; k++)
    begin
      apb(1'b1, IDX_SEL[3], (k == 36) ? 32'hFFFF : k);
      lv(10'h008);
      look(fexp(k));
      lv('0);
    end
    apb(1'b1, IDX_SEL[3], {16'h0, SEL_RST[3]});
    $display("test codes done");
    // counter on terminal six, cleared from terminal two
    apb(1'b1, IDX_SEL[TERM_SIX], FC_CNT_IN);
    apb(1'b1, IDX_SEL[TERM_TWO], FC_CNT_CLR);
    part.pulse(TERM_SIX, 5);
    lv('0);
    rd(IDX_COUNT, 33'd5);
    lv(10'h002);
    lv('0);
    rd(IDX_COUNT, 33'd0);
    // terminal seven pulses only while its selector is zero
    part.pulse(TERM_SEVEN, 3);
    lv('0);
    rd(IDX_PULSE, 33'd3);
    apb(1'b1, IDX_SEL[TERM_SEVEN], FC_INCH);
    part.pulse(TERM_SEVEN, 2);
    lv('0);
    rd(IDX_PULSE, 33'd3);
    $display("test counters done");
    // wiring modes over selectors hold, up and external fault
    apb(1'b1, IDX_SEL[TERM_ONE], FC_HOLD);
    apb(1'b1, IDX_SEL[TERM_TWO], FC_UP);
    apb(1'b1, IDX_SEL[TERM_THREE], FC_EXTF);
    for (int k = 0; k < 14; k++)
    begin
      m = tbl[k];
      apb(1'b1, IDX_MODE, {28'h0, m[11:8]});
      lv({7'h0, m[6:4]});
      look(wexp(m[3:0]));
    end
    $display("test wiring done");
    report_and_stop();
  end
endmodule // tb_digital_input_function_map
`default_nettype wire
